// ---- verif/sram_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sram_defs.svh"

module sram_host_model #(
    parameter int ADDR_W = 10
) (
    input  wire logic                  clk,
    input  wire logic                  dq_oe_n,
    input  wire logic [`DATA_BITS-1:0] dq_out,
    output logic                       clock_gate_n,
    output var sram_pkg::cmd_pins_t    cmd,
    output logic      [ADDR_W-1:0]     address,
    output logic                       output_enable_n,
    output logic                       sleep_request,
    output logic                       burst_order_select,
    output logic                       flow_through_select_n,
    output logic      [`DATA_BITS-1:0] bus
);
    import sram_pkg::*;

    typedef struct packed {
        logic                  v;
        logic [`DATA_BITS-1:0] d;
    } wdata_t;

    wdata_t                pend;
    wdata_t                wq1;
    wdata_t                wq2;
    wdata_t                drv;
    logic [`DATA_BITS-1:0] last;

    initial begin
        clock_gate_n          = 1'h0;
        cmd                   = 9'h0fe;
        address               = '0;
        output_enable_n       = 1'h0;
        sleep_request         = 1'h0;
        burst_order_select    = 1'h0;
        flow_through_select_n = 1'h1;
        pend                  = '0;
        wq1                   = '0;
        wq2                   = '0;
        last                  = '0;
    end

    // ----------------------------------------
    // Command driver and late write data
    // ----------------------------------------
    task automatic put(input logic g, input cmd_pins_t c, input logic [ADDR_W-1:0] a,
                       input logic w, input logic [`DATA_BITS-1:0] d);
        clock_gate_n = g;
        cmd          = c;
        address      = a;
        pend         = {w, d};
        @(posedge clk);
        #2;
    endtask : put

    // Data queue moves only on edges with the clock gate low, asleep or not
    always @(posedge clk) begin
        last <= bus;
        if (!clock_gate_n) begin
            wq1 <= pend;
            wq2 <= wq1;
        end
    end

    assign drv = flow_through_select_n ? wq2 : wq1;

    // Released bus toggles so stale data cannot pass for a read
    always_comb begin
        if (drv.v && !dq_oe_n)
            bus = 'x;
        else if (drv.v)
            bus = drv.d;
        else if (!dq_oe_n)
            bus = dq_out;
        else
            bus = ~last;
    end
endmodule : sram_host_model
`default_nettype wire

// ---- verif/sync_sram_burst_command_control_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sram_defs.svh"

module sync_sram_burst_command_control_test;
    import sram_pkg::*;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] m;
        logic [9:0] a;
    } mop_t;

    logic                  clk;
    logic                  rst_b;
    logic                  clock_gate_n;
    cmd_pins_t             cmd;
    logic [9:0]            address;
    logic                  output_enable_n;
    logic                  sleep_request;
    logic                  burst_order_select;
    logic                  flow_through_select_n;
    logic [`DATA_BITS-1:0] bus;
    logic [`DATA_BITS-1:0] dq_out;
    logic                  dq_oe_n;
    logic [`DATA_BITS-1:0] mem [1024];
    mop_t                  p1, p2, nw, wo, v;
    int                    bst, errors, checked, cyc, age, seed;
    logic [1:0]            st, stp;
    logic [7:0]            blk, wblk;
    logic                  skip, mslp;

    always #20 clk = ~clk;

    sram_host_model #(.ADDR_W(10)) i_host (
        .clk(clk), .dq_oe_n(dq_oe_n), .dq_out(dq_out), .clock_gate_n(clock_gate_n),
        .cmd(cmd), .address(address), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .burst_order_select(burst_order_select),
        .flow_through_select_n(flow_through_select_n), .bus(bus));

    sync_sram_burst_command_control #(.ADDR_W(10)) i_dut (
        .clk(clk), .rst_b(rst_b), .clock_gate_n(clock_gate_n), .cmd(cmd),
        .address(address), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .burst_order_select(burst_order_select),
        .flow_through_select_n(flow_through_select_n), .dq_in(bus),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n));

    // ----------------------------------------
    // Reference model and comparison
    // ----------------------------------------
    task automatic check(input logic [`DATA_BITS-1:0] seen,
                         input logic [`DATA_BITS-1:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cyc++;
        if (cyc > 4000) begin
            errors++;
            summarize();
        end
        if (!rst_b) begin
            p1  = '0;
            p2  = '0;
            bst = 0;
        end else if (!clock_gate_n && !mslp) begin
            wo = flow_through_select_n ? p2 : p1;
            for (int g = 0; g < 4; g++)
                if (wo.wr && wo.m[g]) mem[wo.a][9*g +: 9] = bus[9*g +: 9];
            nw = '0;
            if (!cmd.load_or_advance) begin
                bst = 0;
                if (cmd[2:0] == 3'h2 && (cmd.write_n || cmd.byte_write_n != 4'hf)) begin
                    bst = cmd.write_n ? 1 : 2;
                    {blk, st} = address;
                    stp = 2'h0;
                end
            end else if (bst != 0) begin
                stp++;
            end
            if (bst != 0)
                nw = {bst == 1, bst == 2, ~cmd.byte_write_n,
                      blk, burst_order_select ? st ^ stp : st + stp};
            p2 = p1;
            p1 = nw;
        end
        #1;
        v = flow_through_select_n ? p2 : p1;
        if (!rst_b || mslp)
            check(36'(dq_oe_n), 36'h1);
        else if (!skip && v.rd && !output_enable_n) begin
            check(36'(dq_oe_n), 36'h0);
            check(dq_out, mem[v.a]);
        end else if (!skip)
            check(36'(dq_oe_n), 36'h1);
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic issue(input logic g, lo, wn, input logic [3:0] m,
                         input logic [2:0] cs, input logic [9:0] a);
        logic wv;
        wv = !g && (lo ? bst == 2 : (cs == 3'h2 && !wn && m != 4'hf));
        if (wv)
            age = 0;
        else if (!g)
            age++;
        if (wv && !lo)
            wblk = a[9:2];
        i_host.put(g, {lo, wn, m, cs}, a, wv, 36'({$random(seed), $random(seed)}));
    endtask : issue

    task automatic idle;
        issue(0, 0, 1, 4'hf, 3'h6, 10'h000);
    endtask : idle

    task automatic stall;
        issue(1, 1, 0, 4'h0, 3'h2, 10'h3ff);
    endtask : stall

    // Reads avoid a block whose late write may still be pending
    task automatic rnd;
        logic [31:0] r;
        logic [9:0]  a;
        logic [2:0]  cs;
        r  = $random(seed);
        a  = 10'($random(seed));
        cs = 3'h2;
        if (r[11:9] == 3'h0)
            cs[r[13:12] % 3] = !cs[r[13:12] % 3];
        if (!r[3] && r[4] && a[9:2] == wblk && age < 4)
            a[9] = !a[9];
        issue(r[2:0] == 3'h0, r[3], r[4], r[8:5], cs, a);
    endtask : rnd

    initial begin
        seed    = 49329;
        clk     = 1'h0;
        rst_b   = 1'h0;
        skip    = 1'h0;
        mslp    = 1'h0;
        age     = 9;
        wblk    = 8'h00;
        errors  = 0;
        checked = 0;
        cyc     = 0;
        repeat (2) idle();
        rst_b = 1'h1;
        repeat (3) idle();
        for (int b = 0; b < 256; b++) begin
            issue(0, 0, 0, 4'h0, 3'h2, 10'({b, 2'h0}));
            repeat (3) issue(0, 1, 1, 4'h0, 3'h2, 10'h000);
        end
        for (int p = 0; p < 5; p++) begin
            repeat (4) idle();
            {i_host.burst_order_select, i_host.flow_through_select_n} = 2'(p);
            i_host.output_enable_n = (p == 4);
            repeat (4) idle();
            repeat (300) rnd();
        end
        repeat (4) idle();
        i_host.output_enable_n = 1'h0;
        repeat (4) idle();
        issue(0, 0, 1, 4'hf, 3'h2, 10'h155);
        issue(0, 1, 1, 4'hf, 3'h2, 10'h000);
        skip = 1'h1;
        i_host.sleep_request = 1'h1;
        repeat (8) stall();
        skip = 1'h0;
        mslp = 1'h1;
        repeat (3) issue(0, 0, 1, 4'hf, 3'h2, 10'h2aa);
        mslp = 1'h0;
        skip = 1'h1;
        i_host.sleep_request = 1'h0;
        repeat (8) stall();
        skip = 1'h0;
        repeat (2) issue(0, 1, 1, 4'hf, 3'h2, 10'h000);
        repeat (4) idle();
        summarize();
    end
endmodule : sync_sram_burst_command_control_test
`default_nettype wire

// ---- verilog/burst_counter.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sram_defs.svh"

module burst_counter (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   load,
    input  wire logic                   advance,
    input  wire logic [`BURST_BITS-1:0] start,
    input  wire logic                   interleave,
    output logic      [`BURST_BITS-1:0] next_low
);

    logic [`BURST_BITS-1:0] base;
    logic [`BURST_BITS-1:0] step;
    logic [`BURST_BITS-1:0] next_step;

    assign next_step = step + `BURST_BITS'h1;
    // Wraps back to the loaded value after four accesses
    assign next_low  = interleave ? (base ^ next_step) : (base + next_step);    // [R12] [R13] [R14]

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            base <= '0;
            step <= '0;
        end else if (load) begin
            base <= start;                                                       // [R27]
            step <= '0;
        end else if (advance) begin
            step <= next_step;                                                   // [R6]
        end
    end

endmodule : burst_counter
`default_nettype wire

// ---- verilog/sram_defs.svh ----
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

// ----------------------------------------
// Data bus layout
// ----------------------------------------
`define LANES               4
`define LANE_BITS           9
`define DATA_BITS           36

// ----------------------------------------
// Burst counter
// ----------------------------------------
`define BURST_BITS          2

// ----------------------------------------
// Sleep timing, in clock cycles
// ----------------------------------------
`define SLEEP_ENTRY_TIME    2
`define SLEEP_RECOVERY_TIME 2
`define SLEEP_ENTRY_CYCLES  (`SLEEP_ENTRY_TIME)
`define SLEEP_RECOV_CYCLES  (`SLEEP_RECOVERY_TIME)

// ----------------------------------------
// Reset values of synchronised pins
// ----------------------------------------
`define OE_N_RESET          1'h1
`define FLOW_N_RESET        1'h1
`define ORDER_RESET         1'h0
`define SLEEP_RESET         1'h0

`endif

// ---- verilog/sram_pkg.sv ----
`include "sram_defs.svh"

package sram_pkg;

    // ----------------------------------------
    // Synchronous command pins
    // ----------------------------------------
    typedef struct packed {
        logic                  load_or_advance;
        logic                  write_n;
        logic [`LANES-1:0]     byte_write_n;
        logic                  chip_select_first_n;
        logic                  chip_select_second;
        logic                  chip_select_third_n;
    } cmd_pins_t;

    // ----------------------------------------
    // One access travelling down the pipe
    // ----------------------------------------
    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic [`LANES-1:0]     mask;
    } op_t;

    typedef enum logic [2:0] {
        burst_idle  = 3'h1,
        burst_read  = 3'h2,
        burst_write = 3'h4
    } burst_t;

    typedef enum logic [3:0] {
        sleep_active   = 4'h1,
        sleep_entering = 4'h2,
        sleep_asleep   = 4'h4,
        sleep_waking   = 4'h8
    } sleep_state_t;

endpackage : sram_pkg

// ---- verilog/sync_sram_burst_command_control.sv ----
// Contract
// R1: Selected load cycle with write high begins a read burst at the external address.
// R2: Output enable high makes a read internal only; bus stays high impedance.
// R3: Selected load cycle with write low and some byte write begins a write burst.
// R4: Write low with no byte write is a no-op; nothing written, bus idle.
// R5: Advance continues the current burst from the counter, ignoring write and selects.
// R6: The burst counter advances on every continue cycle of a read or write burst.
// R7: Load cycle with any select inactive deselects and keeps the bus high impedance.
// R8: Advance while deselected only follows a deselect and keeps the bus released.
// R9: Clock gate high makes the edge ignored; address and state hold.
// R10: Stall keeps a pipelined read driving and a write released.
// R11: Drivers turn off during writes so output enable may stay low.
// R12: Two-bit burst counter returns to its start on the fifth clock.
// R13: Burst order select low gives a linear, plus one modulo four, sequence.
// R14: Burst order select high gives start bits XOR step count.
// R15: Flow-through select low gives flow-through timing; high gives pipelined timing.
// R16: Sleep high enters sleep after two cycles, keeping internal state.
// R17: Sleep low resumes normal operation after two cycles.
// R18: While asleep the device is deselected, ignores inputs, releases outputs.
// R19: Controller finishes pending accesses before raising sleep.
// R20: During sleep recovery the controller issues only deselect or read.
// R21: Outputs stay high impedance through power-up.
// R22: Pipelined write data comes at the third edge from the command.
// R23: Flow-through write data comes at the second edge from the command.
// R24: Flow-through read data is driven right after the address edge.
// R25: Each byte write enables its own nine-bit lane; any mix allowed.
// R26: Controller keeps burst order and flow-through selects static.
// R27: Each begin cycle reloads the burst counter from the external low address bits.
`timescale 1ns/10ps
`default_nettype none
`include "sram_defs.svh"

module sync_sram_burst_command_control #(
    parameter int ADDR_W = 10
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   clock_gate_n,
    input  wire sram_pkg::cmd_pins_t    cmd,
    input  wire logic [ADDR_W-1:0]      address,
    input  wire logic                   output_enable_n,
    input  wire logic                   sleep_request,
    input  wire logic                   burst_order_select,
    input  wire logic                   flow_through_select_n,
    input  wire logic [`DATA_BITS-1:0]  dq_in,
    output logic      [`DATA_BITS-1:0]  dq_out,
    output logic                        dq_oe_n
);
    import sram_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    // ----------------------------------------
    // Asynchronous pin synchronisers
    // ----------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic       oe_n_s;
    logic       sleep_s;
    logic       flow_n_s;
    logic       order_s;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_meta <= {`OE_N_RESET, `SLEEP_RESET, `FLOW_N_RESET, `ORDER_RESET};
            pin_sync <= {`OE_N_RESET, `SLEEP_RESET, `FLOW_N_RESET, `ORDER_RESET};
        end else begin
            pin_meta <= {output_enable_n, sleep_request, flow_through_select_n,
                         burst_order_select};
            pin_sync <= pin_meta;
        end
    end

    assign {oe_n_s, sleep_s, flow_n_s, order_s} = pin_sync;

    logic flow;
    assign flow = !flow_n_s;                                                    // [R15]

    // ----------------------------------------
    // Sleep control
    // ----------------------------------------
    sleep_state_t st;
    logic [1:0]   sleep_cnt;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st        <= sleep_active;
            sleep_cnt <= 2'h0;
        end else begin
            case (st)
                sleep_active: begin
                    sleep_cnt <= 2'h0;
                    if (sleep_s) begin
                        st <= sleep_entering;
                    end
                end
                sleep_entering: begin
                    if (!sleep_s) begin
                        st <= sleep_active;
                    end else if (sleep_cnt == 2'(`SLEEP_ENTRY_CYCLES - 1)) begin
                        st        <= sleep_asleep;                              // [R16]
                        sleep_cnt <= 2'h0;
                    end else begin
                        sleep_cnt <= sleep_cnt + 2'h1;
                    end
                end
                sleep_asleep: begin
                    sleep_cnt <= 2'h0;
                    if (!sleep_s) begin
                        st <= sleep_waking;
                    end
                end
                sleep_waking: begin
                    if (sleep_s) begin
                        st        <= sleep_asleep;
                        sleep_cnt <= 2'h0;
                    end else if (sleep_cnt == 2'(`SLEEP_RECOV_CYCLES - 1)) begin
                        st <= sleep_active;                                     // [R17]
                    end else begin
                        sleep_cnt <= sleep_cnt + 2'h1;
                    end
                end
                default: begin
                    st        <= sleep_active;
                    sleep_cnt <= 2'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic        go;
    logic        sel;
    logic        any_byte;
    logic        beg_rd;
    logic        beg_wr;
    logic        beg_abort;
    logic        deselect;
    logic        cont;
    burst_t      burst;
    logic [1:0]  cnt_low;
    logic [ADDR_W-1:0] hi_addr;
    logic [ADDR_W-1:0] cur_addr;
    op_t         cur;

    // Asleep ignores every edge; clock gate high ignores it too
    assign go        = clock_gate_n == 1'b0 && st != sleep_asleep;             // [R9] [R18]
    assign sel       = !cmd.chip_select_first_n && cmd.chip_select_second
                       && !cmd.chip_select_third_n;
    assign any_byte  = cmd.byte_write_n != '1;
    assign beg_rd    = !cmd.load_or_advance && sel && cmd.write_n;              // [R1]
    assign beg_wr    = !cmd.load_or_advance && sel && !cmd.write_n && any_byte; // [R3]
    assign beg_abort = !cmd.load_or_advance && sel && !cmd.write_n && !any_byte;// [R4]
    assign deselect  = !cmd.load_or_advance && !sel;                            // [R7]
    assign cont      = cmd.load_or_advance && burst != burst_idle;              // [R5] [R8]

    always_comb begin
        cur      = '0;
        cur_addr = address;
        if (beg_rd) begin
            cur.rd = 1'b1;
        end else if (beg_wr) begin
            cur.wr   = 1'b1;                                                    // [R25]
            cur.mask = ~cmd.byte_write_n;
        end else if (cont) begin
            cur_addr = {hi_addr[ADDR_W-1:2], cnt_low};                          // [R5]
            cur.rd   = burst == burst_read;
            cur.wr   = burst == burst_write && any_byte;                        // [R4]
            cur.mask = (burst == burst_write) ? ~cmd.byte_write_n : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            burst   <= burst_idle;
            hi_addr <= '0;
        end else if (go) begin
            if (beg_rd) begin
                burst   <= burst_read;
                hi_addr <= address;
            end else if (beg_wr) begin
                burst   <= burst_write;
                hi_addr <= address;
            end else if (beg_abort || deselect) begin
                burst <= burst_idle;                                            // [R7]
            end
        end
    end

    burst_counter counter (
        .clk        (clk),
        .rst_b      (rst_b),
        .load       (go && (beg_rd || beg_wr)),                                 // [R27]
        .advance    (go && cont),                                               // [R6]
        .start      (address[1:0]),
        .interleave (order_s),
        .next_low   (cnt_low)
    );

    // ----------------------------------------
    // Access pipe
    // ----------------------------------------
    op_t               s1;
    op_t               s2;
    logic [ADDR_W-1:0] a1;
    logic [ADDR_W-1:0] a2;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1 <= '0;
            s2 <= '0;
            a1 <= '0;
            a2 <= '0;
        end else if (go) begin                                                  // [R9]
            s1 <= cur;
            s2 <= s1;
            a1 <= cur_addr;
            a2 <= a1;
        end
    end

    // Late write: data taken one edge later in flow-through, two in pipelined
    op_t               wl;
    logic [ADDR_W-1:0] wa;
    op_t               rs;
    logic [ADDR_W-1:0] ra;

    assign wl = flow ? s1 : s2;                                                 // [R22] [R23]
    assign wa = flow ? a1 : a2;
    assign rs = flow ? cur : s1;                                                // [R24]
    assign ra = flow ? cur_addr : a1;

    // ----------------------------------------
    // Storage, one array per byte lane
    // ----------------------------------------
    logic [`DATA_BITS-1:0] rd_word;

    for (genvar g = 0; g < `LANES; g++) begin : lane
        logic [`LANE_BITS-1:0] mem [DEPTH];

        always_ff @(posedge clk) begin
            if (go && wl.wr && wl.mask[g]) begin
                mem[wa] <= dq_in[g*`LANE_BITS +: `LANE_BITS];                   // [R25]
            end
        end

        assign rd_word[g*`LANE_BITS +: `LANE_BITS] = mem[ra];
    end

    // ----------------------------------------
    // Output drivers
    // ----------------------------------------
    logic read_drive;
    logic next_drive;
    logic [1:0] last_low;
    logic sleep_now;

    // Drivers go off at the edge that enters sleep, not one cycle later
    assign sleep_now = st == sleep_asleep || (st == sleep_waking && sleep_s)
                       || (st == sleep_entering && sleep_s
                           && sleep_cnt == 2'(`SLEEP_ENTRY_CYCLES - 1));      // [R18]

    always_comb begin
        if (sleep_now) begin
            next_drive = 1'b0;                                                  // [R18]
        end else if (go) begin
            next_drive = rs.rd;                                                 // [R11]
        end else begin
            next_drive = read_drive;                                            // [R10]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            read_drive <= 1'b0;
            dq_oe_n    <= 1'b1;                                                 // [R21]
            dq_out     <= '0;
        end else begin
            read_drive <= next_drive;
            dq_oe_n    <= !(next_drive && !oe_n_s);                             // [R2]
            if (go && rs.rd) begin
                dq_out <= rd_word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            last_low <= 2'h0;
        end else if (go && (beg_rd || beg_wr || cont)) begin
            last_low <= cur_addr[1:0];
        end
    end

    // Burst start and step count, kept apart from the counter for the checks
    logic [1:0] start_low;
    logic [1:0] seq_n;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_low <= 2'h0;
            seq_n     <= 2'h0;
        end else if (go && (beg_rd || beg_wr)) begin
            start_low <= address[1:0];
            seq_n     <= 2'h0;
        end else if (go && cont) begin
            seq_n <= seq_n + 2'h1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking chk_clk @(posedge clk); endclocking
    default disable iff (!rst_b);

    powerup_hiz_a: assert property (@(posedge clk) disable iff (1'b0) // [R21]
        !rst_b |=> dq_oe_n) else $error("bus driven during reset");
    oe_high_hiz_a: assert property ( // [R2]
        oe_n_s |=> dq_oe_n) else $error("bus driven with output enable high");
    write_no_drive_a: assert property ( // [R11]
        go && flow && cur.wr |=> dq_oe_n) else $error("bus driven in write");
    deselect_hiz_a: assert property ( // [R7]
        go && flow && (deselect || beg_abort) |=> dq_oe_n)
        else $error("bus driven after deselect");
    abort_no_write_a: assert property ( // [R4]
        go && beg_abort |=> !s1.wr && burst == burst_idle)
        else $error("write abort stored a write");
    stall_hold_a: assert property ( // [R9]
        !go |=> $stable(s1) && $stable(a1) && $stable(burst))
        else $error("state moved on an ignored edge");
    stall_drive_a: assert property ( // [R10]
        clock_gate_n && st == sleep_active |=> read_drive == $past(read_drive))
        else $error("stall changed bus drive");
    linear_step_a: assert property ( // [R13]
        go && cont && !order_s |-> cur_addr[1:0] == last_low + 2'h1)
        else $error("linear burst step wrong");
    sleep_entry_a: assert property ( // [R16]
        (st == sleep_active && sleep_s) ##1 sleep_s[*2] |=> st == sleep_asleep)
        else $error("sleep not entered after two cycles");
    wake_up_a: assert property ( // [R17]
        (st == sleep_asleep && !sleep_s) ##1 !sleep_s[*2] |=> st == sleep_active)
        else $error("sleep not left after two cycles");
    sleep_hiz_a: assert property ( // [R18]
        st == sleep_asleep |=> dq_oe_n) else $error("bus driven while asleep");
    asleep_hiz_a: assert property ( // [R18]
        st == sleep_asleep |-> dq_oe_n) else $error("bus driven in first sleep cycle");
    interleave_step_a: assert property ( // [R14]
        go && cont && order_s |-> cur_addr[1:0] == (start_low ^ (seq_n + 2'h1)))
        else $error("interleaved burst step wrong");
    burst_wrap_a: assert property ( // [R12]
        go && cont && seq_n == 2'h3 |-> cur_addr[1:0] == start_low)
        else $error("burst did not wrap to its start");

    read_burst_c:  cover property (go && beg_rd ##1 (go && cont)[*3]);
    write_burst_c: cover property (go && beg_wr ##1 (go && cont && cur.wr)[*3]);
    stall_read_c:  cover property (!dq_oe_n ##1 clock_gate_n);
    sleep_cycle_c: cover property (st == sleep_asleep ##[1:20] st == sleep_active);

endmodule : sync_sram_burst_command_control
`default_nettype wire
